// ===== pkg/smps_pkg.sv
// Constants shared by the switched-mode supply control logic
package smps_pkg;
  // Level scale: one count is one millivolt
  localparam int LVL_W = 13;
  localparam logic [LVL_W-1:0] OSC_HIGH_MV = 13'h1388;  // 5.0 V upper switching threshold
  localparam logic [LVL_W-1:0] OSC_LOW_MV = 13'h07d0;   // 2.0 V lower switching threshold
  localparam logic [LVL_W-1:0] RAMP_MIN_MV = 13'h0708;  // 1.8 V ramp minimum
  localparam logic [LVL_W-1:0] RAMP_MAX_MV = 13'h157c;  // 5.5 V ramp maximum
  localparam logic [LVL_W-1:0] SS_MAX_MV = 13'h1388;    // 5.0 V soft-start clamp
  localparam logic [LVL_W-1:0] SS_SET_MV = 13'h05dc;    // 1.5 V soft-start comparator

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int CL_OFF_NS = 250;
  localparam int CL_OFF_CYC = (CL_OFF_NS / CLK_PERIOD_NS < 1) ? 1 : CL_OFF_NS / CLK_PERIOD_NS;

  // Register map (byte addresses, word aligned)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OSC_RISE_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] OSC_FALL_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] RAMP_RISE_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] SS_CHARGE_OFS = 8'h0c;
  localparam logic [ADDR_W-1:0] SS_DISCH_OFS = 8'h10;
  localparam logic [ADDR_W-1:0] ERR_AMP_OFS = 8'h14;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h18;
  localparam logic [ADDR_W-1:0] LEVELS_OFS = 8'h1c;

  // Reset values of the writable registers
  localparam logic [LVL_W-1:0] OSC_RISE_RST = 13'h0064;
  localparam logic [LVL_W-1:0] OSC_FALL_RST = 13'h0258;
  localparam logic [LVL_W-1:0] RAMP_RISE_RST = 13'h0064;
  localparam logic [LVL_W-1:0] SS_CHARGE_RST = 13'h0003;
  localparam logic [LVL_W-1:0] SS_DISCH_RST = 13'h0001;
  localparam logic [LVL_W-1:0] ERR_AMP_RST = 13'h157c;

  // Status register bit positions
  localparam int ST_GATE = 0;
  localparam int ST_TOFF = 1;
  localparam int ST_ERRFF = 2;
  localparam int ST_FALL = 3;
  localparam int ST_SUPPLY = 4;
  localparam int ST_STBY = 5;
  localparam int ST_OV = 6;
  localparam int ST_UV = 7;
  localparam int ST_REFOC = 8;
  localparam int ST_CLIM = 9;
  localparam int ST_DTRIP = 10;
  localparam int ST_W = 11;

  // Synchroniser vector positions
  localparam int IN_SUPPLY = 0;
  localparam int IN_STBY = 1;
  localparam int IN_DTRIP = 2;
  localparam int IN_CLIM = 3;
  localparam int IN_OV = 4;
  localparam int IN_UV = 5;
  localparam int IN_REFOC = 6;
  localparam int IN_W = 7;
endpackage

// ===== hdl/smps_pwm_control_logic.sv
// PWM control logic of a single-phase switched-mode supply controller
// Functional notes
// [RULE1] Gate off until supply passes turn-on threshold
// [RULE2] Standby undervoltage holds device idle, gate off
// [RULE3] Oscillator falling phase issues trigger pulse
// [RULE4] Ramp locked to oscillator, restarts per trigger
// [RULE5] Ramp compared against lower of two thresholds
// [RULE6] Ramp above threshold resets turn-off flop
// [RULE7] Trigger sets turn-off flop unless reset pending
// [RULE8] Current limit or duty trip reset flop
// [RULE9] Soft-start below 1.5 V requests error set
// [RULE10] Error flop set blocked while fault pending
// [RULE11] Soft-start from zero, rises to 5 V
// [RULE12] Error disables gate, soft-start slowly discharges
// [RULE13] Duty nonzero only above 1.8 V ramp minimum
// [RULE14] Fault forces gate low, restart via soft-start
// [RULE15] Overvoltage, reference overcurrent, undervoltage are errors
// [RULE16] Overvoltage drives hysteresis hold output
// [RULE17] Undervoltage disables gate, restarts via soft-start
// [RULE18] After current limit, re-enable at next trigger
// [RULE19] Current limit turns gate off within 250 ns
// [RULE20] Gate active high, low through falling phase
// [RULE21] Soft-start clamps 5 V, ramp reaches 5.5 V
// [RULE22] Standby holds gate low
// [RULE23] Comparator decisions are synchronised single bits
// [RULE24] Oscillator, ramp, soft-start are counters with increments
//
// Implementation choices: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
module smps_pwm_control_logic
  import smps_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Analog comparator decisions
  input wire logic supply_turn_on_threshold,
  input wire logic standby_undervoltage,
  input wire logic duty_trip_comparator,
  input wire logic current_limit_comparator,
  input wire logic overvoltage_comparator,
  input wire logic undervoltage_comparator,
  input wire logic ref_overcurrent,
  // Outputs to the power stage and sense network
  output logic gate_drive_out,
  output logic ov_hysteresis_out,
  // Avalon-MM slave
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest
);

  function automatic logic [LVL_W-1:0] sat_add(input logic [LVL_W-1:0] a,
                                               input logic [LVL_W-1:0] b,
                                               input logic [LVL_W-1:0] lim);
    logic [LVL_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = (s >= {1'b0, lim}) ? lim : s[LVL_W-1:0];
  endfunction

  function automatic logic [LVL_W-1:0] sat_sub(input logic [LVL_W-1:0] a,
                                               input logic [LVL_W-1:0] b,
                                               input logic [LVL_W-1:0] lim);
    logic [LVL_W:0] floor_v;
    // Widened so a large decrement cannot wrap the floor test
    floor_v = {1'b0, lim} + {1'b0, b};
    sat_sub = ({1'b0, a} <= floor_v) ? lim : a - b;
  endfunction

  logic [IN_W-1:0] meta_r;
  logic [IN_W-1:0] sync_r;
  logic [LVL_W-1:0] osc_rise_r, osc_fall_r, ramp_rise_r, ss_charge_r, ss_disch_r, err_amp_r;
  logic [LVL_W-1:0] osc_r, ramp_r, ss_r;
  logic falling_r, trig_r, toff_r, err_r;
  logic supply_s, stby_s, dtrip_s, clim_s, ov_s, uv_s, refoc_s;
  logic run, fault, error_now, duty_off, ss_low, osc_top;
  logic [LVL_W-1:0] thresh;
  logic [ST_W-1:0] status;

  // Async comparator results pass two flops first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= {ref_overcurrent, undervoltage_comparator, overvoltage_comparator,
                 current_limit_comparator, duty_trip_comparator, standby_undervoltage,
                 supply_turn_on_threshold};
      sync_r <= meta_r; // [RULE23]
    end
  end

  assign supply_s = sync_r[IN_SUPPLY];
  assign stby_s = sync_r[IN_STBY];
  assign dtrip_s = sync_r[IN_DTRIP];
  assign clim_s = sync_r[IN_CLIM];
  assign ov_s = sync_r[IN_OV];
  assign uv_s = sync_r[IN_UV];
  assign refoc_s = sync_r[IN_REFOC];

  assign run = supply_s & ~stby_s; // [RULE1] [RULE2]
  assign fault = ~run | ov_s | uv_s | refoc_s; // [RULE15] [RULE17]
  assign error_now = fault | ~err_r; // [RULE12]
  assign thresh = (err_amp_r < ss_r) ? err_amp_r : ss_r; // [RULE5]
  assign duty_off = dtrip_s | (ramp_r > thresh); // [RULE6]
  assign ss_low = ss_r < SS_SET_MV; // [RULE9]
  assign osc_top = !falling_r &&
                   (sat_add(osc_r, osc_rise_r, OSC_HIGH_MV) == OSC_HIGH_MV); // [RULE3]

  // Oscillator: long rising phase, short falling phase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_r <= OSC_LOW_MV;
      falling_r <= 1'b0;
      trig_r <= 1'b0;
    end else begin
      trig_r <= 1'b0;
      if (!falling_r) begin
        osc_r <= sat_add(osc_r, osc_rise_r, OSC_HIGH_MV); // [RULE24]
        if (osc_top) begin
          falling_r <= 1'b1;
          trig_r <= 1'b1; // [RULE3]
        end
      end else begin
        osc_r <= sat_sub(osc_r, osc_fall_r, OSC_LOW_MV);
        if (sat_sub(osc_r, osc_fall_r, OSC_LOW_MV) == OSC_LOW_MV) begin
          falling_r <= 1'b0;
        end
      end
    end
  end

  // Ramp restarts with the trigger, so the set sees the ramp minimum
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ramp_r <= RAMP_MIN_MV;
    end else if (osc_top || falling_r) begin
      ramp_r <= RAMP_MIN_MV; // [RULE4]
    end else begin
      ramp_r <= sat_add(ramp_r, ramp_rise_r, RAMP_MAX_MV); // [RULE21]
    end
  end

  // Soft-start level; held empty until the supply is up
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ss_r <= '0;
    end else if (!run) begin
      ss_r <= '0; // [RULE11]
    end else if (error_now) begin
      ss_r <= sat_sub(ss_r, ss_disch_r, '0); // [RULE12]
    end else begin
      ss_r <= sat_add(ss_r, ss_charge_r, SS_MAX_MV); // [RULE11] [RULE21]
    end
  end

  // Error flop: reset dominates the soft-start set request
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      err_r <= 1'b0;
    end else if (fault) begin
      err_r <= 1'b0; // [RULE14] [RULE15]
    end else if (ss_low) begin
      err_r <= 1'b1; // [RULE10]
    end
  end

  // Turn-off flop; ramp starts at 1.8 V so a low soft-start keeps it reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      toff_r <= 1'b0;
    end else if (clim_s || duty_off) begin
      toff_r <= 1'b0; // [RULE8] [RULE13]
    end else if (trig_r) begin
      toff_r <= 1'b1; // [RULE7] [RULE18]
    end
  end

  // Gate also masked by live resets to save a cycle on current limit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gate_drive_out <= 1'b0;
      ov_hysteresis_out <= 1'b0;
    end else begin
      gate_drive_out <= toff_r & err_r & ~falling_r & ~fault & ~clim_s; // [RULE19] [RULE20] [RULE22]
      ov_hysteresis_out <= ov_s; // [RULE16]
    end
  end

  assign status = {dtrip_s, clim_s, refoc_s, uv_s, ov_s, stby_s, supply_s,
                   falling_r, err_r, toff_r, gate_drive_out};

  // Bus slave: every access answers one cycle after it appears
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      waitrequest <= 1'b1;
      readdata <= '0;
    end else begin
      waitrequest <= ~((read | write) & waitrequest);
      if (read && waitrequest) begin
        if (address == OSC_RISE_OFS) begin
          readdata <= {19'h0, osc_rise_r};
        end else if (address == OSC_FALL_OFS) begin
          readdata <= {19'h0, osc_fall_r};
        end else if (address == RAMP_RISE_OFS) begin
          readdata <= {19'h0, ramp_rise_r};
        end else if (address == SS_CHARGE_OFS) begin
          readdata <= {19'h0, ss_charge_r};
        end else if (address == SS_DISCH_OFS) begin
          readdata <= {19'h0, ss_disch_r};
        end else if (address == ERR_AMP_OFS) begin
          readdata <= {19'h0, err_amp_r};
        end else if (address == STATUS_OFS) begin
          readdata <= {21'h0, status};
        end else if (address == LEVELS_OFS) begin
          readdata <= {3'h0, ramp_r, 3'h0, ss_r};
        end else begin
          readdata <= '0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      osc_rise_r <= OSC_RISE_RST;
      osc_fall_r <= OSC_FALL_RST;
      ramp_rise_r <= RAMP_RISE_RST;
      ss_charge_r <= SS_CHARGE_RST;
      ss_disch_r <= SS_DISCH_RST;
      err_amp_r <= ERR_AMP_RST;
    end else if (write && !waitrequest) begin
      if (address == OSC_RISE_OFS) begin
        osc_rise_r <= writedata[LVL_W-1:0]; // [RULE24]
      end else if (address == OSC_FALL_OFS) begin
        osc_fall_r <= writedata[LVL_W-1:0];
      end else if (address == RAMP_RISE_OFS) begin
        ramp_rise_r <= writedata[LVL_W-1:0];
      end else if (address == SS_CHARGE_OFS) begin
        ss_charge_r <= writedata[LVL_W-1:0];
      end else if (address == SS_DISCH_OFS) begin
        ss_disch_r <= writedata[LVL_W-1:0];
      end else if (address == ERR_AMP_OFS) begin
        err_amp_r <= writedata[LVL_W-1:0];
      end
    end
  end

  // Checking helpers
  logic [7:0] clim_hi_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      clim_hi_cnt <= '0;
    end else if (clim_s && gate_drive_out) begin
      clim_hi_cnt <= clim_hi_cnt + 8'h01;
    end else begin
      clim_hi_cnt <= '0;
    end
  end

  sequence s_fault_drop;
    fault ##1 !err_r;
  endsequence

  property p_supply_gate;
    @(posedge clk) disable iff (!rstn) !supply_s |=> !gate_drive_out;
  endproperty
  a_supply_gate: assert property (p_supply_gate) else $error("gate on below turn-on"); // [RULE1]

  property p_standby;
    @(posedge clk) disable iff (!rstn) stby_s |=> !gate_drive_out && ss_r == '0;
  endproperty
  a_standby: assert property (p_standby) else $error("gate or soft-start live in standby"); // [RULE2]

  property p_trig_pulse;
    @(posedge clk) disable iff (!rstn) trig_r |-> falling_r ##1 !trig_r;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger not single pulse"); // [RULE3]

  property p_ramp_restart;
    @(posedge clk) disable iff (!rstn) trig_r |=> ramp_r == RAMP_MIN_MV;
  endproperty
  a_ramp_restart: assert property (p_ramp_restart) else $error("ramp not restarted"); // [RULE4]

  property p_duty_off;
    @(posedge clk) disable iff (!rstn) (ramp_r > thresh) |=> !toff_r;
  endproperty
  a_duty_off: assert property (p_duty_off) else $error("turn-off flop not reset"); // [RULE6]

  property p_toff_set;
    @(posedge clk) disable iff (!rstn) $rose(toff_r) |-> $past(trig_r) && !$past(clim_s);
  endproperty
  a_toff_set: assert property (p_toff_set) else $error("turn-off flop set off trigger"); // [RULE18]

  property p_fault_drop;
    @(posedge clk) disable iff (!rstn) fault |-> s_fault_drop ##1 !gate_drive_out;
  endproperty
  a_fault_drop: assert property (p_fault_drop) else $error("fault did not drop gate"); // [RULE14]

  property p_ss_clamp;
    @(posedge clk) disable iff (!rstn) ss_r <= SS_MAX_MV && ramp_r <= RAMP_MAX_MV;
  endproperty
  a_ss_clamp: assert property (p_ss_clamp) else $error("level above clamp"); // [RULE21]

  property p_clim;
    @(posedge clk) disable iff (!rstn) clim_hi_cnt < 8'(CL_OFF_CYC);
  endproperty
  a_clim: assert property (p_clim) else $error("current limit too slow"); // [RULE19]

  property p_dead_time;
    @(posedge clk) disable iff (!rstn) falling_r |=> !gate_drive_out;
  endproperty
  a_dead_time: assert property (p_dead_time) else $error("gate high in falling phase"); // [RULE20]

  property p_ov_hold;
    @(posedge clk) disable iff (!rstn) ov_s |=> ov_hysteresis_out;
  endproperty
  a_ov_hold: assert property (p_ov_hold) else $error("overvoltage hold missing"); // [RULE16]

  property p_err_gate;
    @(posedge clk) disable iff (!rstn) !err_r |=> !gate_drive_out;
  endproperty
  a_err_gate: assert property (p_err_gate) else $error("gate on with error flop clear"); // [RULE12]

  property p_err_set;
    @(posedge clk) disable iff (!rstn) (!fault && ss_low) |=> err_r;
  endproperty
  a_err_set: assert property (p_err_set) else $error("error flop not set"); // [RULE9]

  property p_err_block;
    @(posedge clk) disable iff (!rstn) $rose(err_r) |-> !$past(fault);
  endproperty
  a_err_block: assert property (p_err_block) else $error("error flop set under fault"); // [RULE10]

  property p_ss_charge;
    @(posedge clk) disable iff (!rstn) (run && !error_now) |=> ss_r >= $past(ss_r);
  endproperty
  a_ss_charge: assert property (p_ss_charge) else $error("soft-start fell while charging"); // [RULE11]

  property p_ss_disch;
    @(posedge clk) disable iff (!rstn) (run && error_now) |=> ss_r <= $past(ss_r);
  endproperty
  a_ss_disch: assert property (p_ss_disch) else $error("soft-start rose under error"); // [RULE12]

  property p_low_ss;
    @(posedge clk) disable iff (!rstn) (ss_r < RAMP_MIN_MV) |-> ##2 !gate_drive_out;
  endproperty
  a_low_ss: assert property (p_low_ss) else $error("duty below ramp minimum"); // [RULE13]

  property p_gate_src;
    @(posedge clk) disable iff (!rstn) gate_drive_out |-> $past(toff_r) && !$past(falling_r);
  endproperty
  a_gate_src: assert property (p_gate_src) else $error("gate without turn-off flop"); // [RULE20]

  property p_trig_start;
    @(posedge clk) disable iff (!rstn) $rose(falling_r) |-> trig_r;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("falling phase without trigger"); // [RULE3]

  property p_ramp_low;
    @(posedge clk) disable iff (!rstn) falling_r |-> ramp_r == RAMP_MIN_MV;
  endproperty
  a_ramp_low: assert property (p_ramp_low) else $error("ramp not at minimum"); // [RULE4]

  property p_clim_toff;
    @(posedge clk) disable iff (!rstn) clim_s |=> !toff_r;
  endproperty
  a_clim_toff: assert property (p_clim_toff) else $error("limit left flop set"); // [RULE8]

  property p_toff_trig;
    @(posedge clk) disable iff (!rstn) (trig_r && !clim_s && !duty_off) |=> toff_r;
  endproperty
  a_toff_trig: assert property (p_toff_trig) else $error("trigger did not set flop"); // [RULE7]

  property p_uv_gate;
    @(posedge clk) disable iff (!rstn) uv_s |=> !gate_drive_out;
  endproperty
  a_uv_gate: assert property (p_uv_gate) else $error("gate on in undervoltage"); // [RULE17]

  property p_ov_release;
    @(posedge clk) disable iff (!rstn) !ov_s |=> !ov_hysteresis_out;
  endproperty
  a_ov_release: assert property (p_ov_release) else $error("hold without overvoltage"); // [RULE16]
endmodule

// ===== testbench/smps_sense_model.sv
// Sense comparators and power switch that face the control logic
`timescale 1ns/1ps
module smps_sense_model
  import smps_pkg::*;
(
  // Commanded analog conditions, indexed like the synchroniser vector
  input wire logic [IN_W-1:0] cond,
  // Gate of the power switch
  input wire logic gate_drive_out,
  // Comparator decisions
  output logic supply_turn_on_threshold,
  output logic standby_undervoltage,
  output logic duty_trip_comparator,
  output logic current_limit_comparator,
  output logic overvoltage_comparator,
  output logic undervoltage_comparator,
  output logic ref_overcurrent
);
  assign supply_turn_on_threshold = cond[IN_SUPPLY];
  assign standby_undervoltage = cond[IN_STBY];
  assign duty_trip_comparator = cond[IN_DTRIP];
  // No drain current, so no overcurrent, while the switch is off
  assign current_limit_comparator = cond[IN_CLIM] & gate_drive_out;
  assign overvoltage_comparator = cond[IN_OV];
  assign undervoltage_comparator = cond[IN_UV];
  assign ref_overcurrent = cond[IN_REFOC];
endmodule

// ===== testbench/smps_pwm_control_logic_tb.sv
// Self-checking bench for the PWM control logic
`timescale 1ns/1ps
module smps_pwm_control_logic_tb;
  import smps_pkg::*;
  logic clk;
  logic rstn;
  logic [IN_W-1:0] cond;
  logic sup, stb, dtr, clm, ovc, uvc, roc;
  logic gate_drive_out;
  logic ov_hysteresis_out;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic [31:0] rd;
  logic [LVL_W-1:0] rst_tab [6];
  int flt [5];
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int hi;

  smps_sense_model smps_sense_model_inst (.cond(cond), .gate_drive_out(gate_drive_out),
    .supply_turn_on_threshold(sup), .standby_undervoltage(stb),
    .duty_trip_comparator(dtr), .current_limit_comparator(clm),
    .overvoltage_comparator(ovc), .undervoltage_comparator(uvc), .ref_overcurrent(roc));

  smps_pwm_control_logic smps_pwm_control_logic_inst (.clk(clk), .rstn(rstn),
    .supply_turn_on_threshold(sup), .standby_undervoltage(stb),
    .duty_trip_comparator(dtr), .current_limit_comparator(clm),
    .overvoltage_comparator(ovc), .undervoltage_comparator(uvc), .ref_overcurrent(roc),
    .gate_drive_out(gate_drive_out), .ov_hysteresis_out(ov_hysteresis_out),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // One Avalon transfer; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do @(posedge clk); while (waitrequest !== 1'b0);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_gate(input logic v, input int lim, input string what);
    int n;
    n = 0;
    while (gate_drive_out !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    check(what, gate_drive_out, v);
  endtask

  // Settle past the synchroniser first, then count gate-high cycles
  task automatic count_high(input int n);
    repeat (5) @(posedge clk);
    hi = 0;
    repeat (n) begin
      @(posedge clk);
      if (gate_drive_out === 1'b1) hi++;
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      bad_count++;
      conclude();
    end
  end

  initial begin
    rstn = 1'b0;
    cond = '0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    rst_tab = '{OSC_RISE_RST, OSC_FALL_RST, RAMP_RISE_RST, SS_CHARGE_RST, SS_DISCH_RST,
                ERR_AMP_RST};
    flt = '{IN_OV, IN_UV, IN_REFOC, IN_STBY, IN_SUPPLY};
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, ADDR_W'(i * 4), '0);
      check("reset value", rd, {19'h0, rst_tab[i]});
    end
    bus(1'b1, 8'h40, 32'h0000_1234);
    bus(1'b0, 8'h40, '0);
    check("unmapped read", rd, 32'h0);
    bus(1'b1, ERR_AMP_OFS, 32'hffff_1abc);
    bus(1'b0, ERR_AMP_OFS, '0);
    check("threshold readback", rd, 32'h0000_1abc);
    bus(1'b1, ERR_AMP_OFS, 32'(ERR_AMP_RST));
    count_high(300);
    check("gate without supply", hi, 0);
    cond[IN_SUPPLY] <= 1'b1;
    wait_gate(1'b1, 3000, "gate after turn-on");
    wait_gate(1'b0, 60, "gate dead time");
    wait_gate(1'b1, 60, "gate next period");
    // Threshold below the ramp minimum leaves no duty at all
    bus(1'b1, ERR_AMP_OFS, 32'h0000_0600);
    count_high(200);
    check("gate under ramp minimum", hi, 0);
    bus(1'b1, ERR_AMP_OFS, 32'(ERR_AMP_RST));
    cond[IN_DTRIP] <= 1'b1;
    count_high(200);
    check("gate under duty trip", hi, 0);
    cond[IN_DTRIP] <= 1'b0;
    wait_gate(1'b1, 100, "gate before limit");
    repeat (2) @(posedge clk);
    cond[IN_CLIM] <= 1'b1;
    wait_gate(1'b0, 25, "gate at current limit");
    cond[IN_CLIM] <= 1'b0;
    count_high(10);
    check("gate held after limit", hi, 0);
    wait_gate(1'b1, 60, "gate at next trigger");
    foreach (flt[k]) begin
      wait_gate(1'b1, 100, "gate before fault");
      cond[flt[k]] <= ~cond[flt[k]];
      wait_gate(1'b0, 5, "gate at fault");
      repeat (2) @(posedge clk);
      check("hysteresis hold", ov_hysteresis_out, flt[k] == IN_OV);
      count_high(200);
      check("gate during fault", hi, 0);
      bus(1'b0, STATUS_OFS, '0);
      check("status gate", rd[ST_GATE], 1'b0);
      check("status error flop", rd[ST_ERRFF], 1'b0);
      check("status standby", rd[ST_STBY], cond[IN_STBY]);
      check("status overvoltage", rd[ST_OV], cond[IN_OV]);
      cond[flt[k]] <= ~cond[flt[k]];
      wait_gate(1'b1, 8000, "gate after fault");
      check("hysteresis released", ov_hysteresis_out, 1'b0);
    end
    repeat (1500) @(posedge clk);
    bus(1'b0, LEVELS_OFS, '0);
    check("soft-start clamp", rd[12:0], SS_MAX_MV);
    check("ramp ceiling", rd[28:16] <= RAMP_MAX_MV, 1'b1);
    conclude();
  end
endmodule
